//--- core/mpp_pkg.sv
// Package of constants for the parallel programming port controller.
package mpp_pkg;
    // ----------------------------------------
    // Operation select codes
    // ----------------------------------------
    localparam logic [3:0] OP_READ       = 4'h0; // Normal array read.
    localparam logic [3:0] OP_ERASE      = 4'h1; // Chip erase.
    localparam logic [3:0] OP_PROGRAM    = 4'h3; // Byte program.
    localparam logic [3:0] OP_BLANK_CHK  = 4'h4; // Erase verify read.
    localparam logic [3:0] OP_WRITE_CHK  = 4'h5; // Program verify read.
    localparam logic [3:0] OP_PROT_PGM   = 4'h6; // Protection bit program.
    localparam logic [3:0] OP_PROT_BLANK = 4'h9; // Protection erased check.
    localparam logic [3:0] OP_PROT_CHK   = 4'hb; // Protection programmed check.
    localparam logic [3:0] OP_INIT       = 4'he; // Initialize.
    localparam logic [3:0] OP_IDENT      = 4'hf; // Identification read.

    // ----------------------------------------
    // Command register map of the controller
    // ----------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0; // Write: bit 3:0 op, bit 8 go.
    localparam logic [3:0] REG_ADDR   = 4'h4; // Byte address, 14 bits.
    localparam logic [3:0] REG_WDATA  = 4'h8; // Data to program.
    localparam logic [3:0] REG_STATUS = 4'hc; // Busy, fail, result byte.
    localparam int CTRL_GO_BIT     = 8;      // Start bit in the control word.
    localparam int ST_BUSY_BIT     = 8;      // Busy flag position.
    localparam int ST_FAIL_BIT     = 9;      // Failure flag position.
    localparam int ST_TRIES_LSB    = 16;     // Retry count field start.

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ       = 125;                       // Core clock rate.
    localparam int PROG_PULSE_NS = 10000;                     // Program strobe 10 us.
    localparam int LONG_PULSE_MS = 500;                       // Erase strobe 0.5 s.
    localparam int SETUP_NS      = 200;                       // Mode and address setup.
    localparam int ACCESS_NS     = 200;                       // Read access allowance.
    localparam int PROG_PULSE_CYC = (PROG_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_PULSE_CYC = LONG_PULSE_MS * 1000 * CLK_MHZ;
    localparam int SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC     = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_TRIES      = 25;                       // Program retry bound.

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        MPP_IDLE   = 3'b000,
        MPP_SETUP  = 3'b001,
        MPP_STROBE = 3'b011,
        MPP_RECOV  = 3'b010,
        MPP_READ   = 3'b110,
        MPP_DONE   = 3'b111
    } mpp_state_t;
endpackage

//--- core/mpp_ctrl.sv
// Controller that drives the parallel programming pins of the code memory.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module mpp_ctrl #(
    parameter int LONG_PULSE_CYC = mpp_pkg::LONG_PULSE_CYC,
    parameter int MAX_TRIES      = mpp_pkg::MAX_TRIES
) (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Command port.
    input  wire logic [3:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    output logic      [31:0] cmd_rdata,
    // Programming pins.
    output logic      [13:0] prog_byte_address,
    output logic      [3:0]  prog_op_select,
    output logic             prog_chip_enable_n,
    output logic             prog_output_enable_n,
    output logic             prog_write_strobe_n,
    input  wire logic [7:0]  prog_data_in,
    output logic      [7:0]  prog_data_out,
    output logic             prog_data_oe
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // True for ops that pulse the write strobe.
    function automatic logic is_strobe_op(input logic [3:0] op);
        return op == mpp_pkg::OP_PROGRAM || op == mpp_pkg::OP_ERASE ||
               op == mpp_pkg::OP_INIT || op == mpp_pkg::OP_PROT_PGM;
    endfunction

    // True for the long erase-style pulses.
    function automatic logic is_long_op(input logic [3:0] op);
        return op == mpp_pkg::OP_ERASE || op == mpp_pkg::OP_INIT;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    mpp_pkg::mpp_state_t state;       // Sequencer state.
    logic [3:0]  op;                  // Current operation.
    logic [13:0] addr;                // Programmed address.
    logic [7:0]  wdata;               // Byte to program.
    logic [7:0]  result;              // Last byte read back.
    logic        fail;                // Program retries ran out.
    logic [7:0]  tries;               // Pulses given to this byte.
    logic        verify;              // Current read is a program check.
    logic [31:0] timer;               // Phase timer.
    logic [7:0]  din_meta;            // First sync stage of data pins.
    logic [7:0]  din_sync;            // Second sync stage of data pins.
    logic        busy;                // Sequence in progress.

    assign busy = (state != mpp_pkg::MPP_IDLE);

    // Data pins come from the far device, so pass two flops.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            din_meta <= 8'h00;
            din_sync <= 8'h00;
        end
        else
        begin
            din_meta <= prog_data_in;
            din_sync <= din_meta;
        end
    end

    // Command register writes capture address and data while idle; op is taken only by a go write.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr  <= 14'h0000;
            wdata <= 8'h00;
        end
        else if (cmd_write && !busy)
        begin
            if (cmd_addr == mpp_pkg::REG_ADDR)
            begin
                addr <= cmd_wdata[13:0];
            end
            else if (cmd_addr == mpp_pkg::REG_WDATA)
            begin
                wdata <= cmd_wdata[7:0];
            end
        end
    end

    // Read data stand in the cycle after the read strobe.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_rdata <= 32'h0000_0000;
        end
        else if (cmd_read && cmd_addr == mpp_pkg::REG_STATUS)
        begin
            cmd_rdata <= {8'h00, tries, 6'h00, fail, busy, result};
        end
        else if (cmd_read && cmd_addr == mpp_pkg::REG_ADDR)
        begin
            cmd_rdata <= {18'h00000, addr};
        end
        else if (cmd_read && cmd_addr == mpp_pkg::REG_WDATA)
        begin
            cmd_rdata <= {24'h000000, wdata};
        end
        else if (cmd_read && cmd_addr == mpp_pkg::REG_CTRL)
        begin
            cmd_rdata <= {28'h0000000, op};
        end
        else
        begin
            // Unmapped or no read gives zero.
            cmd_rdata <= 32'h0000_0000;
        end
    end

    // Main sequencer: setup, strobe or read, recovery, retry.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state  <= mpp_pkg::MPP_IDLE;
            op     <= mpp_pkg::OP_READ;
            timer  <= 32'h0000_0000;
            tries  <= 8'h00;
            verify <= 1'b0;
            fail   <= 1'b0;
            result <= 8'h00;
        end
        else
        begin
            case (state)
                mpp_pkg::MPP_IDLE:
                begin
                    // A go write starts a sequence; a control write without the go bit is dropped.
                    if (cmd_write && cmd_addr == mpp_pkg::REG_CTRL &&
                        cmd_wdata[mpp_pkg::CTRL_GO_BIT])
                    begin
                        op     <= cmd_wdata[3:0];
                        tries  <= 8'h00;
                        verify <= 1'b0;
                        fail   <= 1'b0;
                        timer  <= 32'h0000_0000;
                        state  <= mpp_pkg::MPP_SETUP;
                    end
                end
                mpp_pkg::MPP_SETUP:
                begin
                    // Hold mode and address stable before strobe or output enable.
                    if (timer >= 32'(mpp_pkg::SETUP_CYC - 1))
                    begin
                        timer <= 32'h0000_0000;
                        if (is_strobe_op(op) && !verify)
                        begin
                            state <= mpp_pkg::MPP_STROBE;
                        end
                        else
                        begin
                            state <= mpp_pkg::MPP_READ;
                        end
                    end
                    else
                    begin
                        timer <= timer + 32'h1;
                    end
                end
                mpp_pkg::MPP_STROBE:
                begin
                    // Long pulse for erase and initialize, short otherwise.
                    if ((is_long_op(op) && timer >= 32'(LONG_PULSE_CYC - 1)) ||
                        (!is_long_op(op) &&
                         timer >= 32'(mpp_pkg::PROG_PULSE_CYC - 1)))
                    begin
                        timer <= 32'h0000_0000;
                        tries <= tries + 8'h01;
                        state <= mpp_pkg::MPP_RECOV;
                    end
                    else
                    begin
                        timer <= timer + 32'h1;
                    end
                end
                mpp_pkg::MPP_RECOV:
                begin
                    // After a program pulse, switch to a write-check read.
                    if (timer >= 32'(mpp_pkg::SETUP_CYC - 1))
                    begin
                        timer <= 32'h0000_0000;
                        if (op == mpp_pkg::OP_PROGRAM)
                        begin
                            verify <= 1'b1;
                            state  <= mpp_pkg::MPP_SETUP;
                        end
                        else
                        begin
                            state <= mpp_pkg::MPP_DONE;
                        end
                    end
                    else
                    begin
                        timer <= timer + 32'h1;
                    end
                end
                mpp_pkg::MPP_READ:
                begin
                    // Sample the synchronised bus after the access time.
                    if (timer >= 32'(mpp_pkg::ACCESS_CYC + 1))
                    begin
                        timer  <= 32'h0000_0000;
                        result <= din_sync;
                        if (verify && din_sync != wdata)
                        begin
                            // Mismatch: pulse again or give up.
                            verify <= 1'b0;
                            if (tries >= 8'(MAX_TRIES))
                            begin
                                fail  <= 1'b1;
                                state <= mpp_pkg::MPP_DONE;
                            end
                            else
                            begin
                                state <= mpp_pkg::MPP_SETUP;
                            end
                        end
                        else
                        begin
                            state <= mpp_pkg::MPP_DONE;
                        end
                    end
                    else
                    begin
                        timer <= timer + 32'h1;
                    end
                end
                mpp_pkg::MPP_DONE:
                begin
                    // Release the device for one cycle before idling.
                    state <= mpp_pkg::MPP_IDLE;
                end
                default:
                begin
                    state <= mpp_pkg::MPP_IDLE;
                end
            endcase
        end
    end

    // Pin drive, registered from the sequencer state.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prog_chip_enable_n   <= 1'b1;
            prog_output_enable_n <= 1'b1;
            prog_write_strobe_n  <= 1'b1;
            prog_op_select       <= mpp_pkg::OP_READ;
            prog_byte_address    <= 14'h0000;
            prog_data_out        <= 8'hff;
            prog_data_oe         <= 1'b0;
        end
        else
        begin
            // Standby with chip enable high whenever idle.
            prog_chip_enable_n   <= !(busy && state != mpp_pkg::MPP_DONE);
            prog_write_strobe_n  <= (state != mpp_pkg::MPP_STROBE);
            prog_output_enable_n <= (state != mpp_pkg::MPP_READ);
            prog_op_select       <= verify ? mpp_pkg::OP_WRITE_CHK : op;
            prog_byte_address    <= addr;
            prog_data_out        <= wdata;
            // Drive data only for writes, never while output enable is low.
            prog_data_oe <= (op == mpp_pkg::OP_PROGRAM) && !verify &&
                            (state == mpp_pkg::MPP_SETUP ||
                             state == mpp_pkg::MPP_STROBE ||
                             state == mpp_pkg::MPP_RECOV);
        end
    end
endmodule

`default_nettype wire

//--- bench/mpp_ctrl_checker.sv
// Assertions on the programming pins of the port controller.
`timescale 1ns/1ps
`default_nettype none
module mpp_ctrl_checker #(
    parameter int LONG_PULSE_CYC = mpp_pkg::LONG_PULSE_CYC,
    parameter int MAX_TRIES      = mpp_pkg::MAX_TRIES
) (
    // Clock, reset and command port.
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [3:0]  cmd_addr,
    input wire logic [31:0] cmd_wdata,
    input wire logic        cmd_write,
    input wire logic        cmd_read,
    input wire logic [31:0] cmd_rdata,
    // Programming pins.
    input wire logic [13:0] prog_byte_address,
    input wire logic [3:0]  prog_op_select,
    input wire logic        prog_chip_enable_n,
    input wire logic        prog_output_enable_n,
    input wire logic        prog_write_strobe_n,
    input wire logic [7:0]  prog_data_in,
    input wire logic [7:0]  prog_data_out,
    input wire logic        prog_data_oe
);
    wire logic [3:0] op = prog_op_select;        // Short alias of the mode pins.
    wire logic       ce = ~prog_chip_enable_n;   // Chip enable asserted.
    wire logic       oe = ~prog_output_enable_n; // Output enable asserted.
    wire logic       we = ~prog_write_strobe_n;  // Write strobe asserted.
    logic [31:0]     low_cyc;                    // Cycles the strobe has been low.
    // Measures each strobe pulse so its width can be judged when it ends.
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn) low_cyc <= 32'h0;
        else if (we) low_cyc <= low_cyc + 32'h1;
        else low_cyc <= 32'h0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_ce_gates_pins: assert property ((we || oe) |-> ce)
        else $error("Strobe or output enable active with chip enable high.");
    a_bus_turn: assert property (oe |-> !prog_data_oe && !we)
        else $error("Controller drives data while reading.");
    a_read_mode: assert property (oe |-> op inside {4'h0, 4'h4, 4'h5, 4'h9, 4'hb, 4'hf})
        else $error("Output enable with a write mode.");
    a_strobe_mode: assert property (we |-> op inside {4'h1, 4'h3, 4'h6, 4'he})
        else $error("Write strobe with a read mode.");
    a_strobe_hold: assert property (we && $past(we) |-> $stable(op)
        && $stable(prog_byte_address) && $stable(prog_data_out))
        else $error("Mode, address or data moved during a strobe.");
    a_prog_data: assert property (we && op == 4'h3 |-> prog_data_oe)
        else $error("Program strobe without data driven.");
    a_short_pulse: assert property ($rose(prog_write_strobe_n)
        && $past(op) inside {4'h3, 4'h6} |-> low_cyc == mpp_pkg::PROG_PULSE_CYC)
        else $error("Program pulse width wrong.");
    a_long_pulse: assert property ($rose(prog_write_strobe_n)
        && $past(op) inside {4'h1, 4'he} |-> low_cyc == LONG_PULSE_CYC)
        else $error("Erase or initialize pulse width wrong.");
    a_verify_after: assert property ($rose(prog_write_strobe_n)
        && $past(op) == 4'h3 |-> ##[1:200] (oe && op == 4'h5))
        else $error("No verify read after a program pulse.");
    c_prog: cover property ($rose(prog_write_strobe_n) && $past(op) == 4'h3);
    c_erase: cover property ($rose(prog_write_strobe_n) && $past(op) == 4'h1);
    c_prot_read: cover property (oe && op == 4'hb);
endmodule
bind mpp_ctrl mpp_ctrl_checker #(.LONG_PULSE_CYC(LONG_PULSE_CYC), .MAX_TRIES(MAX_TRIES)) u_chk (
    .core_clk, .resetn, .cmd_addr, .cmd_wdata, .cmd_write, .cmd_read, .cmd_rdata,
    .prog_byte_address, .prog_op_select, .prog_chip_enable_n, .prog_output_enable_n,
    .prog_write_strobe_n, .prog_data_in, .prog_data_out, .prog_data_oe);
`default_nettype wire

//--- bench/mpp_dev_model.sv
// Behavioural model of the code memory behind the programming pins.
`timescale 1ns/1ps
`default_nettype none
module mpp_dev_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
    parameter logic [7:0] PART_CODE  = 8'h47  // Arbitrary value.
) (
    // Programming pins and resolved data bus.
    input wire logic [13:0] prog_byte_address,
    input wire logic [3:0]  prog_op_select,
    input wire logic        prog_chip_enable_n,
    input wire logic        prog_output_enable_n,
    input wire logic        prog_write_strobe_n,
    input wire logic [7:0]  prog_data_out,
    input wire logic        prog_data_oe,
    input wire logic        stuck,
    output logic      [7:0] prog_data_in
);
    logic [7:0] mem [0:16383]; // One byte per 14-bit address.
    logic [3:1] prot = 3'h0;   // Protection bits.
    logic [7:0] rd_val;        // Byte offered in read modes.
    logic [7:0] last = 8'hff;  // Last level seen on the bus.
    wire logic drv = !prog_chip_enable_n && !prog_output_enable_n && prog_write_strobe_n;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hff;
    end
    // Strobe actions; a stuck cell ignores program pulses.
    always @(negedge prog_write_strobe_n)
        if (!prog_chip_enable_n && prog_output_enable_n)
            case (prog_op_select)
                4'h1: begin foreach (mem[i]) mem[i] = 8'hff; prot = 3'h0; end
                4'he: prot = 3'h0;
                4'h3: if (!stuck) mem[prog_byte_address] &= prog_data_out;
                4'h6: prot[prog_byte_address[1] ? 3 : prog_byte_address[0] ? 2 : 1] = 1'b1;
                default: ;
            endcase
    // Read modes; only the second protection bit hides the array.
    always_comb
        case (prog_op_select)
            4'h0, 4'h4, 4'h5: rd_val = prot[2] ? 8'h00 : mem[prog_byte_address];
            4'h9, 4'hb: rd_val = {4'h0, prot, 1'b0};
            4'hf: rd_val = prog_byte_address[0] ? PART_CODE : MAKER_CODE;
            default: rd_val = 8'hff;
        endcase
    // A released bus shows the inverse of its last level.
    always @*
        if (drv) last = rd_val;
        else if (prog_data_oe) last = prog_data_out;
    assign prog_data_in = drv ? rd_val : prog_data_oe ? prog_data_out : ~last;
endmodule
`default_nettype wire

//--- bench/mpp_ctrl_tb.sv
// Self-checking bench for the programming port controller.
`timescale 1ns/1ps
`default_nettype none
module mpp_ctrl_tb;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
    localparam logic [7:0] PART  = 8'h47; // Arbitrary value.
    logic core_clk = 0, resetn = 0, cmd_write = 0, cmd_read = 0, stuck = 0;
    logic [3:0]  cmd_addr = 4'h0;
    logic [31:0] cmd_wdata = 32'h0, cmd_rdata, st;
    logic [13:0] prog_byte_address;
    logic [3:0]  prog_op_select;
    logic        prog_chip_enable_n, prog_output_enable_n, prog_write_strobe_n, prog_data_oe;
    logic [7:0]  prog_data_in, prog_data_out;
    int          n_fail = 0, compares = 0;
    mpp_ctrl #(.LONG_PULSE_CYC(100), .MAX_TRIES(3)) DUT (.core_clk, .resetn, .cmd_addr,
        .cmd_wdata, .cmd_write, .cmd_read, .cmd_rdata, .prog_byte_address, .prog_op_select,
        .prog_chip_enable_n, .prog_output_enable_n, .prog_write_strobe_n, .prog_data_in,
        .prog_data_out, .prog_data_oe);
    mpp_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_dev (.prog_byte_address,
        .prog_op_select, .prog_chip_enable_n, .prog_output_enable_n, .prog_write_strobe_n,
        .prog_data_out, .prog_data_oe, .stuck, .prog_data_in);
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cmd_write <= 1'b1; cmd_addr <= a; cmd_wdata <= d;
        @(posedge core_clk);
        cmd_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        cmd_read <= 1'b1; cmd_addr <= a;
        @(posedge core_clk);
        cmd_read <= 1'b0;
        @(negedge core_clk);
        d = cmd_rdata;
    endtask
    // Polls status until the sequence ends, bounded.
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            rd(mpp_pkg::REG_STATUS, st);
            n++;
        end
        while (st[mpp_pkg::ST_BUSY_BIT] !== 1'b0 && n < 4000);
        // A sequence that never ends counts as a mismatch.
        if (st[mpp_pkg::ST_BUSY_BIT] !== 1'b0)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t sequence never ended", $time);
        end
    endtask
    task automatic run(input logic [3:0] op, input logic [13:0] a, input logic [7:0] d);
        wr(mpp_pkg::REG_ADDR, {18'h0, a});
        wr(mpp_pkg::REG_WDATA, {24'h0, d});
        wr(mpp_pkg::REG_CTRL, {23'h0, 1'b1, 4'h0, op});
        wait_idle();
    endtask
    // Runs one operation and compares flags and result byte.
    task automatic t(input logic [3:0] op, input logic [13:0] a, input logic [7:0] e);
        run(op, a, 8'h0);
        chk({22'h0, st[9:0]}, {24'h0, e});
    endtask
    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        chk({28'h0, prog_chip_enable_n, prog_output_enable_n, prog_write_strobe_n, prog_data_oe}, 32'he);
        resetn <= 1'b1;
        rd(4'h2, st);
        chk(st, 32'h0);
        t(4'hf, 14'h0, MAKER);
        t(4'hf, 14'h1, PART);
        wr(mpp_pkg::REG_CTRL, 32'h10f);
        wr(mpp_pkg::REG_ADDR, 32'h0);
        wr(mpp_pkg::REG_CTRL, 32'h100);
        wait_idle();
        chk(st[9:0], {2'b00, PART});
        run(4'h1, 14'h1555, 8'h0);
        chk(st[9:8], 2'b00);
        t(4'h4, 14'h3fff, 8'hff);
        t(4'h9, 14'h0, 8'h00);
        run(4'h3, 14'h2a5a, 8'h5a);
        chk(st[23:0], 24'h01005a);
        rd(mpp_pkg::REG_ADDR, st);
        chk(st, 32'h0000_2a5a);
        rd(mpp_pkg::REG_WDATA, st);
        chk(st, 32'h0000_005a);
        rd(mpp_pkg::REG_CTRL, st);
        chk(st, 32'h0000_0003);
        t(4'h0, 14'h2a5a, 8'h5a);
        t(4'h5, 14'h2a5a, 8'h5a);
        t(4'h0, 14'h0a5a, 8'hff);
        stuck <= 1'b1;
        run(4'h3, 14'h0005, 8'h00);
        chk(st[23:8], 16'h0302);
        stuck <= 1'b0;
        run(4'h6, 14'h0, 8'h0);
        t(4'hb, 14'h0, 8'h02);
        run(4'h6, 14'h2, 8'h0);
        t(4'hb, 14'h0, 8'h0a);
        t(4'h0, 14'h2a5a, 8'h5a);
        run(4'h6, 14'h1, 8'h0);
        t(4'hb, 14'h0, 8'h0e);
        t(4'h0, 14'h2a5a, 8'h00);
        t(4'h4, 14'h2a5a, 8'h00);
        t(4'h5, 14'h2a5a, 8'h00);
        run(4'h1, 14'h0, 8'h0);
        t(4'h9, 14'h0, 8'h00);
        t(4'h0, 14'h2a5a, 8'hff);
        run(4'h6, 14'h1, 8'h0);
        t(4'hb, 14'h0, 8'h04);
        run(4'he, 14'h0, 8'h0);
        t(4'h9, 14'h0, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
